// *** hw/eeprom_access_controller.sv ***
// Register front end of the data memory access controller
`timescale 1ns/1ps
module eeprom_access_controller import nv_pkg::*; #(
  parameter int MEM_BYTES = 256,
  parameter int OSC_KHZ = 8000,
  parameter int CNT_W = 16,
  parameter int ATOMIC_TICKS = (T_ATOMIC_US * OSC_KHZ + KHZ_PER_MHZ - 1) / KHZ_PER_MHZ,
  parameter int SPLIT_TICKS = (T_SPLIT_US * OSC_KHZ + KHZ_PER_MHZ - 1) / KHZ_PER_MHZ
) (
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  input wire logic por_nrst_in,
  input wire logic ce_in,
  input wire logic osc_clk_in,
  input wire logic [5:0] io_addr_in,
  input wire logic io_wr_in,
  input wire logic io_rd_in,
  input wire logic [7:0] io_wdata_in,
  input wire logic gie_in,
  output logic [7:0] io_rdata_out,
  output logic cpu_stall_out,
  output logic ready_irq_out
);
  localparam int AW = $clog2(MEM_BYTES);
  localparam logic [8:0] ADDR_MASK = 9'(MEM_BYTES - 1);
  localparam logic [2:0] CNT3_ONE = 3'h1;
  localparam logic [2:0] CNT3_ZERO = 3'h0;

  // ----------------------------------------------------------------
  // Reset release and oscillator synchronisers
  // ----------------------------------------------------------------
  logic rst_meta_r, rst_n_r;
  logic por_meta_r, por_n_r;
  logic osc_meta_r, osc_sync_r, osc_prev_r;

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rst_meta_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r <= rst_meta_r;
    end
  end

  always_ff @(posedge sys_clk_in or negedge por_nrst_in) begin
    if (!por_nrst_in) begin
      por_meta_r <= 1'b0;
      por_n_r <= 1'b0;
    end else begin
      por_meta_r <= 1'b1;
      por_n_r <= por_meta_r;
    end
  end

  // Oscillator ticks stay alive through system reset so timing carries on
  always_ff @(posedge sys_clk_in or negedge por_n_r) begin
    if (!por_n_r) begin
      osc_meta_r <= 1'b0;
      osc_sync_r <= 1'b0;
      osc_prev_r <= 1'b0;
    end else if (ce_in) begin
      osc_meta_r <= osc_clk_in;
      osc_sync_r <= osc_meta_r;
      osc_prev_r <= osc_sync_r;
    end
  end

  wire osc_tick = osc_sync_r & ~osc_prev_r;

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  prog_mode_e mode_r;
  logic rie_r;
  logic arm_r;
  logic [2:0] arm_cnt_r, arm_cnt_nxt;
  logic [7:0] data_r;
  logic [8:0] addr_r;
  logic [2:0] stall_cnt_r, stall_cnt_nxt;
  logic stall_out_r;
  logic [7:0] rdata_r;
  logic irq_r;

  nv_prog_if #(.ADDR_W(AW)) prog ();

  wire busy = prog.busy;

  // ----------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------
  // CPU is halted during a stall, so any bus write then is dropped
  wire wr_ok = io_wr_in & ~stall_out_r;
  wire wr_ctl = wr_ok & (io_addr_in == OFS_CTRL);
  wire wr_data = wr_ok & (io_addr_in == OFS_DATA);
  wire wr_alo = wr_ok & (io_addr_in == OFS_ADDR_LO) & ~busy;
  wire wr_ahi = wr_ok & (io_addr_in == OFS_ADDR_HI) & ~busy;
  wire set_arm = wr_ctl & io_wdata_in[B_ARM];
  wire mode_ok = (mode_r != MODE_RSVD);
  wire start_go = wr_ctl & io_wdata_in[B_TRIG] & arm_r & ~busy & mode_ok;
  wire rd_go = wr_ctl & io_wdata_in[B_RD] & ~busy & ~start_go;
  wire [1:0] mode_wr = io_wdata_in[B_MODE_HI:B_MODE_LO];
  wire [8:0] alo_val = {addr_r[8], io_wdata_in} & ADDR_MASK;
  wire [8:0] ahi_val = {io_wdata_in[B_ADDR9], addr_r[7:0]} & ADDR_MASK;

  assign prog.start = start_go;
  assign prog.op = mode_r;
  assign prog.addr = addr_r[AW-1:0];
  assign prog.wdata = data_r;
  assign prog.tick = osc_tick;

  // ----------------------------------------------------------------
  // Arming window
  // ----------------------------------------------------------------
  always_comb begin
    arm_cnt_nxt = arm_cnt_r;
    if (set_arm) begin
      arm_cnt_nxt = ARM_CYCLES;
    end else if (arm_cnt_r != CNT3_ZERO) begin
      arm_cnt_nxt = arm_cnt_r - CNT3_ONE;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_r) begin
    if (!rst_n_r) begin
      arm_cnt_r <= CNT3_ZERO;
      arm_r <= 1'b0;
    end else if (ce_in) begin
      arm_cnt_r <= arm_cnt_nxt;
      arm_r <= set_arm | (arm_r & (arm_cnt_r != CNT3_ONE));
    end
  end

  // ----------------------------------------------------------------
  // Mode field survives a reset taken while programming
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in or negedge por_n_r) begin
    if (!por_n_r) begin
      mode_r <= MODE_ATOMIC;
    end else if (ce_in) begin
      if (!rst_n_r && !busy) begin
        mode_r <= MODE_ATOMIC;
      end else if (rst_n_r && wr_ctl && !busy) begin
        mode_r <= prog_mode_e'(mode_wr);
      end
    end
  end

  // ----------------------------------------------------------------
  // Enable, data and address registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in or negedge rst_n_r) begin
    if (!rst_n_r) begin
      rie_r <= 1'b0;
      data_r <= DATA_RESET;
      addr_r <= ADDR_RESET;
    end else if (ce_in) begin
      if (wr_ctl) begin
        rie_r <= io_wdata_in[B_RIE];
      end
      if (rd_go) begin
        data_r <= prog.rdata;
      end else if (wr_data) begin
        data_r <= io_wdata_in;
      end
      if (wr_alo) begin
        addr_r <= alo_val;
      end else if (wr_ahi) begin
        addr_r <= ahi_val;
      end
    end
  end

  // ----------------------------------------------------------------
  // CPU stall
  // ----------------------------------------------------------------
  always_comb begin
    stall_cnt_nxt = stall_cnt_r;
    if (start_go) begin
      stall_cnt_nxt = WR_STALL;
    end else if (rd_go) begin
      stall_cnt_nxt = RD_STALL;
    end else if (stall_cnt_r != CNT3_ZERO) begin
      stall_cnt_nxt = stall_cnt_r - CNT3_ONE;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_r) begin
    if (!rst_n_r) begin
      stall_cnt_r <= CNT3_ZERO;
      stall_out_r <= 1'b0;
    end else if (ce_in) begin
      stall_cnt_r <= stall_cnt_nxt;
      stall_out_r <= (stall_cnt_nxt != CNT3_ZERO);
    end
  end

  // ----------------------------------------------------------------
  // Read-back and ready interrupt
  // ----------------------------------------------------------------
  // Strobe bit is a pulse and always reads back as zero
  wire [7:0] ctl_view = {2'b00, mode_r, rie_r, arm_r, busy, 1'b0};
  wire [7:0] rd_mux = (io_addr_in == OFS_CTRL) ? ctl_view :
                      (io_addr_in == OFS_DATA) ? data_r :
                      (io_addr_in == OFS_ADDR_LO) ? addr_r[7:0] :
                      (io_addr_in == OFS_ADDR_HI) ? {7'h00, addr_r[8]} : 8'h00;
  wire irq_nxt = rie_r & gie_in & ~busy;

  always_ff @(posedge sys_clk_in or negedge rst_n_r) begin
    if (!rst_n_r) begin
      rdata_r <= 8'h00;
      irq_r <= 1'b0;
    end else if (ce_in) begin
      if (io_rd_in) begin
        rdata_r <= rd_mux;
      end
      irq_r <= irq_nxt;
    end
  end

  assign io_rdata_out = rdata_r;
  assign cpu_stall_out = stall_out_r;
  assign ready_irq_out = irq_r;

  // ----------------------------------------------------------------
  // Programming engine
  // ----------------------------------------------------------------
  nv_prog_engine #(
    .MEM_BYTES(MEM_BYTES),
    .CNT_W(CNT_W),
    .ATOMIC_TICKS(ATOMIC_TICKS),
    .SPLIT_TICKS(SPLIT_TICKS)
  ) u_engine (
    .clk_in(sys_clk_in),
    .ce_in(ce_in),
    .por_n_in(por_n_r),
    .prog(prog)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_r);

  sequence s_arm;
    (set_arm && ce_in) ##1 (ce_in && !set_arm) [*4];
  endsequence
  sequence s_read;
    (rd_go && ce_in) ##1 ce_in [*4];
  endsequence
  sequence s_start;
    (start_go && ce_in) ##1 ce_in [*2];
  endsequence

  a_arm_expires: assert property (s_arm |=> !arm_r)
    else $error("Arm bit still set after four cycles");
  a_arm_open: assert property (s_arm |-> $past(arm_r, 1) && $past(arm_r, 3))
    else $error("Arm bit closed early");
  a_trig_needs_arm: assert property (start_go |-> arm_r && !busy)
    else $error("Programming started without arm");
  a_trig_busy: assert property ((start_go && ce_in) |=> busy)
    else $error("Trigger bit not set after start");
  a_read_stall: assert property (s_read |-> stall_out_r && $past(stall_out_r, 3))
    else $error("Read stall shorter than four cycles");
  a_read_stall_end: assert property (s_read ##1 ce_in |-> !stall_out_r)
    else $error("Read stall longer than four cycles");
  a_write_stall: assert property (s_start |-> stall_out_r && $past(stall_out_r))
    else $error("Write stall shorter than two cycles");
  a_write_stall_end: assert property (s_start ##1 ce_in |-> !stall_out_r)
    else $error("Write stall longer than two cycles");
  a_read_data: assert property ((rd_go && ce_in) |=> data_r == $past(prog.rdata))
    else $error("Data register missed read byte");
  a_addr_frozen: assert property ((busy && $past(busy)) |-> addr_r == $past(addr_r))
    else $error("Address changed while programming");
  a_mode_frozen: assert property (@(posedge sys_clk_in) disable iff (!por_n_r)
    (busy && ce_in) |=> mode_r == $past(mode_r))
    else $error("Mode changed while programming");
  a_mode_reset: assert property (@(posedge sys_clk_in) disable iff (!por_n_r)
    (!rst_n_r && !busy && ce_in) |=> mode_r == MODE_ATOMIC)
    else $error("Mode not cleared by reset");
  a_irq_busy: assert property ((busy && ce_in) |=> !ready_irq_out)
    else $error("Ready interrupt raised while busy");
  a_high_addr: assert property (io_rdata_out[7:1] == 7'h00 || $past(io_addr_in) != OFS_ADDR_HI
    || !$past(io_rd_in))
    else $error("High address reserved bits not zero");

  // Strobes and triggers that land at the wrong time must leave no trace
  sequence s_busy_strobe;
    ce_in && busy && wr_ctl && io_wdata_in[B_RD];
  endsequence
  sequence s_trig_unarmed;
    ce_in && !busy && !arm_r && wr_ctl && io_wdata_in[B_TRIG];
  endsequence

  a_busy_no_read: assert property (s_busy_strobe |=> !stall_out_r && $stable(data_r))
    else $error("Read strobe acted while programming");
  a_trig_unarmed: assert property (s_trig_unarmed |=> !busy)
    else $error("Programming started without arm window");
  // Checked on every control read, so a stray bit shows up at any point of the run
  a_ctl_view: assert property ((ce_in && io_rd_in && io_addr_in == OFS_CTRL) |=>
    (io_rdata_out >> (B_MODE_HI + 1)) == 8'h00 && !io_rdata_out[B_RD] && io_rdata_out[B_TRIG] == $past(busy))
    else $error("Control read-back layout wrong");
  a_irq_level: assert property (ce_in |=> ready_irq_out == $past(rie_r && gie_in && !busy))
    else $error("Ready interrupt level wrong");

endmodule

// *** hw/nv_pkg.sv ***
// Constants and types shared by the data memory access controller
//
// Operation
// - Master arm bit self-clears four clock cycles after software sets it.
// - Trigger bit starts programming only while the arm bit is still set.
// - Mode 00 erase+write 3.4ms, 01 erase 1.8ms, 10 write 1.8ms, 11 reserved.
// - Trigger bit stays set while programming, hardware clears it when time elapses.
// - Setting the trigger bit stalls the CPU for two cycles.
// - Read strobe loads the addressed byte into data register, CPU stalls four cycles.
// - Read data valid right after strobe; data register supplies the byte to program.
// - While programming, read strobes are ignored and the address cannot change.
// - While the trigger bit is set, writes to the mode field are ignored.
// - Reset returns the mode field to 00 unless programming is in progress.
// - A reset during programming does not abort it; programming completes.
// - Ready interrupt is a level while enabled, globally enabled and memory ready.
// - Control: mode 5:4, irq enable 3, arm 2, trigger 1, strobe 0; 7:6 zero.
// - High address bit 0 exists only in the 512-byte variant; others read zero.
// - Bytes addressed linearly; in the 128-byte variant low address bit 7 reads zero.
// - Programming time is counted on the calibrated oscillator, not the CPU clock.
// - While busy, no other memory operation, including a new trigger, is accepted.
package nv_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [5:0] OFS_CTRL = 6'h1C;
  localparam logic [5:0] OFS_DATA = 6'h1D;
  localparam logic [5:0] OFS_ADDR_LO = 6'h1E;
  localparam logic [5:0] OFS_ADDR_HI = 6'h1F;

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int B_RD = 0;
  localparam int B_TRIG = 1;
  localparam int B_ARM = 2;
  localparam int B_RIE = 3;
  localparam int B_MODE_LO = 4;
  localparam int B_MODE_HI = 5;
  localparam int B_ADDR9 = 0;

  typedef enum logic [1:0] {
    MODE_ATOMIC = 2'h0,
    MODE_ERASE = 2'h1,
    MODE_WRITE = 2'h2,
    MODE_RSVD = 2'h3
  } prog_mode_e;

  // ----------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [8:0] ADDR_RESET = 9'h000;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [2:0] ARM_CYCLES = 3'h4;
  localparam logic [2:0] RD_STALL = 3'h4;
  localparam logic [2:0] WR_STALL = 3'h2;
  localparam int T_ATOMIC_US = 3400;
  localparam int T_SPLIT_US = 1800;
  localparam int KHZ_PER_MHZ = 1000;

endpackage

// *** hw/nv_prog_engine.sv ***
// Self-timed programming engine and byte storage
`timescale 1ns/1ps
module nv_prog_engine import nv_pkg::*; #(
  parameter int MEM_BYTES = 256,
  parameter int CNT_W = 16,
  parameter int ATOMIC_TICKS = 27200,
  parameter int SPLIT_TICKS = 14400
) (
  input wire logic clk_in,
  input wire logic ce_in,
  input wire logic por_n_in,
  nv_prog_if.eng prog
);
  localparam int AW = $clog2(MEM_BYTES);
  localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);
  localparam logic [CNT_W-1:0] LOAD_ATOMIC = CNT_W'(ATOMIC_TICKS);
  localparam logic [CNT_W-1:0] LOAD_SPLIT = CNT_W'(SPLIT_TICKS);

  typedef enum logic [1:0] {ST_IDLE = 2'h1, ST_BUSY = 2'h2} eng_state_e;

  eng_state_e state_r, state_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  prog_mode_e op_r;
  logic [AW-1:0] addr_r;
  logic [7:0] data_r;
  logic [7:0] mem_r [MEM_BYTES];

  wire accept = prog.start & (state_r == ST_IDLE);
  wire done = (state_r == ST_BUSY) & prog.tick & (cnt_r == CNT_ONE);
  wire [7:0] old_byte = mem_r[addr_r];
  wire [7:0] new_byte = (op_r == MODE_ERASE) ? ERASED_BYTE :
                        (op_r == MODE_WRITE) ? (old_byte & data_r) : data_r;
  wire [CNT_W-1:0] load = (prog.op == MODE_ATOMIC) ? LOAD_ATOMIC : LOAD_SPLIT;

  assign prog.busy = (state_r == ST_BUSY);
  assign prog.rdata = mem_r[prog.addr];

  // ----------------------------------------------------------------
  // Busy counter, only ticks of the calibrated oscillator count
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    case (state_r)
      ST_IDLE: begin
        if (accept) begin
          state_nxt = ST_BUSY;
          cnt_nxt = load;
        end
      end
      ST_BUSY: begin
        if (done) begin
          state_nxt = ST_IDLE;
        end else if (prog.tick) begin
          cnt_nxt = cnt_r - CNT_ONE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  // Only power-on clears the engine, so a system reset lets it finish
  always_ff @(posedge clk_in or negedge por_n_in) begin
    if (!por_n_in) begin
      state_r <= ST_IDLE;
      cnt_r <= '0;
    end else if (ce_in) begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  always_ff @(posedge clk_in) begin
    if (ce_in && accept) begin
      op_r <= prog.op;
      addr_r <= prog.addr;
      data_r <= prog.wdata;
    end
  end

  // ----------------------------------------------------------------
  // Storage, committed when the programming time ends
  // ----------------------------------------------------------------
  for (genvar i = 0; i < MEM_BYTES; i++) begin : g_byte
    always_ff @(posedge clk_in) begin
      if (ce_in && done && (addr_r == AW'(i))) begin
        mem_r[i] <= new_byte;
      end
    end
  end

  a_count_holds: assert property (@(posedge clk_in) disable iff (!por_n_in)
    (ce_in && prog.busy && !prog.tick) |=> (cnt_r == $past(cnt_r)))
    else $error("Busy count moved without an oscillator tick");
  a_done_ends: assert property (@(posedge clk_in) disable iff (!por_n_in)
    (ce_in && done) |=> !prog.busy)
    else $error("Busy did not end at count zero");

endmodule

// *** hw/nv_prog_if.sv ***
// Carrier between the register front end and the programming engine
`timescale 1ns/1ps
interface nv_prog_if import nv_pkg::*; #(parameter int ADDR_W = 8);
  logic start;
  prog_mode_e op;
  logic [ADDR_W-1:0] addr;
  logic [7:0] wdata;
  logic tick;
  logic busy;
  logic [7:0] rdata;
  modport ctl (output start, op, addr, wdata, tick, input busy, rdata);
  modport eng (input start, op, addr, wdata, tick, output busy, rdata);
endinterface

// *** verification/tb.sv ***
// Self-checking testbench for the data memory access controller
`timescale 1ns/1ps
module tb import nv_pkg::*;;
  // ------------------------------------------------------------
  // Setup
  // ------------------------------------------------------------
  // Short programming counts keep the run brief
  localparam int AT = 20;
  localparam int SP = 10;
  localparam int OC = 10;
  logic sys_clk_in, nrst_in, por_nrst_in, ce_in, osc_clk_in, io_wr_in, io_rd_in, gie_in;
  logic [5:0] io_addr_in;
  logic [7:0] io_wdata_in, io_rdata_out, v, d, cur;
  logic cpu_stall_out, ready_irq_out, rie_v;
  logic [8:0] a;
  logic [8:0] aq [8];
  logic [7:0] dq [8];
  logic [5:0] ofs [5] = '{OFS_CTRL, OFS_DATA, OFS_ADDR_LO, OFS_ADDR_HI, 6'h10};
  logic [1:0] mt [5] = '{2'h0, 2'h1, 2'h2, 2'h2, 2'h3};
  int n_mismatch = 0;
  int num_checks = 0;
  int cyc = 0;
  int seed = 35;

  eeprom_access_controller #(.MEM_BYTES(256), .ATOMIC_TICKS(AT), .SPLIT_TICKS(SP)) u_eeprom_access_controller (
    .sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .por_nrst_in(por_nrst_in), .ce_in(ce_in),
    .osc_clk_in(osc_clk_in), .io_addr_in(io_addr_in), .io_wr_in(io_wr_in), .io_rd_in(io_rd_in),
    .io_wdata_in(io_wdata_in), .gie_in(gie_in), .io_rdata_out(io_rdata_out),
    .cpu_stall_out(cpu_stall_out), .ready_irq_out(ready_irq_out));

  initial begin
    sys_clk_in = 1'b0;
    forever #4 sys_clk_in = ~sys_clk_in;
  end
  // Oscillator unrelated in phase to the system clock
  initial begin
    osc_clk_in = 1'b0;
    #3;
    forever #40 osc_clk_in = ~osc_clk_in;
  end
  always @(posedge sys_clk_in) cyc <= cyc + 1;

  // ------------------------------------------------------------
  // Reporting
  // ------------------------------------------------------------
  task automatic complete_run;
    $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic chkn(input int g, input int e);
    num_checks++;
    if (g != e) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic hang;
    n_mismatch++;
    $display("[ERR] t=%0t wait bound hit got=%h exp=%h", $time, 1, 0);
    complete_run();
  endtask
  task automatic end_test(input string s);
    $display("test done: %s", s);
  endtask

  // ------------------------------------------------------------
  // Bus cycles, all entered just after a falling edge
  // ------------------------------------------------------------
  task automatic idle_bus;
    int k;
    k = 0;
    while (cpu_stall_out !== 1'b0) begin
      k++;
      if (k > 20) hang();
      @(negedge sys_clk_in);
    end
  endtask
  // One idle edge ahead keeps the write strobe low between back-to-back writes
  task automatic wr(input logic [5:0] ad, input logic [7:0] dt);
    @(negedge sys_clk_in);
    idle_bus();
    io_addr_in = ad;
    io_wdata_in = dt;
    io_wr_in = 1'b1;
    @(negedge sys_clk_in);
    io_wr_in = 1'b0;
  endtask
  task automatic rd(input logic [5:0] ad, output logic [7:0] dt);
    idle_bus();
    io_addr_in = ad;
    io_rd_in = 1'b1;
    @(negedge sys_clk_in);
    io_rd_in = 1'b0;
    @(negedge sys_clk_in);
    dt = io_rdata_out;
  endtask
  task automatic do_rst(input logic p);
    nrst_in = 1'b0;
    por_nrst_in = ~p;
    repeat (5) @(negedge sys_clk_in);
    nrst_in = 1'b1;
    por_nrst_in = 1'b1;
    repeat (3) @(negedge sys_clk_in);
  endtask
  // Counts stalled cycles in a window longer than any stall
  task automatic stalls(input int e);
    int c;
    c = 0;
    repeat (8) begin
      if (cpu_stall_out === 1'b1) c++;
      @(negedge sys_clk_in);
    end
    chkn(c, e);
  endtask

  // ------------------------------------------------------------
  // Memory operations and expectations
  // ------------------------------------------------------------
  function automatic logic [7:0] exp_of(logic [1:0] m, logic [7:0] o, logic [7:0] n);
    case (m)
      2'h0: return n;
      2'h1: return ERASED_BYTE;
      2'h2: return o & n;
      default: return o;
    endcase
  endfunction
  function automatic int ticks_of(logic [1:0] m);
    return (m == 2'h0) ? AT : (m == 2'h3) ? 0 : SP;
  endfunction
  task automatic set_addr(input logic [8:0] ad);
    wr(OFS_ADDR_LO, ad[7:0]);
    wr(OFS_ADDR_HI, {7'h00, ad[8]});
  endtask
  task automatic start(input logic [1:0] m, input logic [8:0] ad, input logic [7:0] dt);
    set_addr(ad);
    wr(OFS_DATA, dt);
    wr(OFS_CTRL, {2'h0, m, rie_v, 3'h4});
    wr(OFS_CTRL, {2'h0, m, rie_v, 3'h2});
  endtask
  task automatic wait_done;
    int k;
    k = 0;
    v = 8'h02;
    while (v[1] !== 1'b0) begin
      k++;
      if (k > 200) hang();
      rd(OFS_CTRL, v);
    end
  endtask
  task automatic prog(input logic [1:0] m, input logic [8:0] ad, input logic [7:0] dt);
    int t0;
    int tk;
    tk = ticks_of(m);
    start(m, ad, dt);
    t0 = cyc;
    stalls((m == 2'h3) ? 0 : int'(WR_STALL));
    rd(OFS_CTRL, v);
    chk8(v, {2'h0, m, rie_v, 1'b0, m != 2'h3, 1'b0});
    wait_done();
    chkn((cyc - t0) >= (tk - 1) * OC && (cyc - t0) <= (tk + 2) * OC + 8, 1);
  endtask
  task automatic readback(input logic [8:0] ad, input logic [7:0] e);
    set_addr(ad);
    wr(OFS_CTRL, {4'h0, rie_v, 3'h1});
    stalls(int'(RD_STALL));
    rd(OFS_DATA, v);
    chk8(v, e);
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    rie_v = 1'b0;
    nrst_in = 1'b0;
    por_nrst_in = 1'b0;
    ce_in = 1'b1;
    io_addr_in = 6'h00;
    io_wr_in = 1'b0;
    io_rd_in = 1'b0;
    io_wdata_in = 8'h00;
    gie_in = 1'b0;
    @(negedge sys_clk_in);
    do_rst(1'b1);
    for (int i = 0; i < 5; i++) begin
      rd(ofs[i], v);
      chk8(v, 8'h00);
    end
    wr(OFS_ADDR_LO, 8'hA5);
    rd(OFS_ADDR_LO, v);
    chk8(v, 8'hA5);
    wr(OFS_ADDR_HI, 8'hFF);
    rd(OFS_ADDR_HI, v);
    chk8(v, 8'h00);
    end_test("registers");
    wr(OFS_CTRL, 8'h04);
    rd(OFS_CTRL, v);
    chk8(v, 8'h04);
    repeat (4) @(negedge sys_clk_in);
    rd(OFS_CTRL, v);
    chk8(v, 8'h00);
    wr(OFS_CTRL, 8'h02);
    stalls(0);
    rd(OFS_CTRL, v);
    chk8(v, 8'h00);
    end_test("arm window");
    a = {1'b0, 8'($random(seed))};
    cur = 8'h00;
    for (int i = 0; i < 5; i++) begin
      d = 8'($random(seed));
      prog(mt[i], a, d);
      cur = exp_of(mt[i], cur, d);
      readback(a, cur);
    end
    end_test("modes");
    start(2'h0, a, 8'hC3);
    wr(OFS_CTRL, 8'h14);
    wr(OFS_CTRL, 8'h12);
    stalls(0);
    wr(OFS_ADDR_LO, ~a[7:0]);
    wr(OFS_CTRL, 8'h01);
    stalls(0);
    rd(OFS_ADDR_LO, v);
    chk8(v, a[7:0]);
    rd(OFS_DATA, v);
    chk8(v, 8'hC3);
    rd(OFS_CTRL, v);
    chk8(v, 8'h02);
    wait_done();
    readback(a, 8'hC3);
    end_test("busy refusals");
    start(2'h1, a, 8'h00);
    repeat (20) @(negedge sys_clk_in);
    do_rst(1'b0);
    rd(OFS_CTRL, v);
    chk8(v, 8'h12);
    wait_done();
    readback(a, ERASED_BYTE);
    wr(OFS_CTRL, 8'h20);
    do_rst(1'b0);
    rd(OFS_CTRL, v);
    chk8(v, 8'h00);
    end_test("reset");
    for (int i = 0; i < 4; i++) begin
      gie_in = i[1];
      rie_v = i[0];
      wr(OFS_CTRL, {4'h0, rie_v, 3'h0});
      repeat (2) @(negedge sys_clk_in);
      chk8({7'h00, ready_irq_out}, {7'h00, rie_v & gie_in});
    end
    start(2'h0, a, 8'h77);
    repeat (6) @(negedge sys_clk_in);
    chk8({7'h00, ready_irq_out}, 8'h00);
    wait_done();
    repeat (2) @(negedge sys_clk_in);
    chk8({7'h00, ready_irq_out}, 8'h01);
    rie_v = 1'b0;
    gie_in = 1'b0;
    end_test("ready interrupt");
    for (int i = 0; i < 8; i++) begin
      aq[i] = (i == 0) ? 9'h000 : (i == 7) ? 9'h0FF : {1'b0, i[2:0], 5'($random(seed))};
      dq[i] = 8'($random(seed));
      prog(2'h0, aq[i], dq[i]);
    end
    for (int i = 0; i < 8; i++) begin
      readback(aq[i], dq[i]);
    end
    end_test("random sweep");
    wr(OFS_DATA, 8'h3C);
    ce_in = 1'b0;
    wr(OFS_DATA, 8'h5A);
    ce_in = 1'b1;
    rd(OFS_DATA, v);
    chk8(v, 8'h3C);
    end_test("clock enable");
    complete_run();
  end
endmodule
